// >>> led_driver_serial_load_port.sv
/*
  top of the serial load port: link shifter on the host serial clock, word
  capture on the system clock, registered display line drive.
  assumes the host stops sclk while the load strobe is high and that the
  variant strap is static; the display content comes from decode logic
  on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module led_driver_serial_load_port (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic                                   sclk,
  input  wire logic                                   sdata_in,
  input  wire logic                                   load_strobe,
  input  wire logic                                   variant_cs,
  input  wire logic [led_port_pkg::DIGIT_COUNT-1:0]   digit_on,
  input  wire logic [led_port_pkg::SEGMENT_COUNT-1:0] segment_on,
  input  wire logic                                   point_on,
  output var  logic                                   sdata_out,
  output var  logic [led_port_pkg::WORD_BITS-1:0]     word_data,
  output var  logic                                   word_valid,
  output var  logic                                   programmed,
  output var  logic                                   cs_mode,
  output var  logic [led_port_pkg::DIGIT_COUNT-1:0]   digit_lines_out,
  output var  logic [led_port_pkg::DIGIT_COUNT-1:0]   digit_lines_oe,
  output var  logic [led_port_pkg::SEGMENT_COUNT-1:0] segment_lines_out,
  output var  logic [led_port_pkg::SEGMENT_COUNT-1:0] segment_lines_oe,
  output var  logic                                   decimal_point_line_out,
  output var  logic                                   decimal_point_line_oe
);
  localparam int CAPTURE_LATENCY = 5;

  shift_if lnk ();

  // strap capture state
  logic [1:0] strap_sync;
  logic [1:0] strap_count;
  logic [1:0] next_strap_count;
  logic       next_cs_mode;

  // strobe synchroniser and edge detect
  logic [2:0] strobe_sync;
  logic       strobe_rise;

  // word synchroniser bank
  logic [led_port_pkg::WORD_BITS-1:0] word_meta;
  logic [led_port_pkg::WORD_BITS-1:0] word_sync;

  // capture state machine
  led_port_pkg::capture_state_e       state;
  led_port_pkg::capture_state_e       next_state;
  logic [2:0]                         settle_count;
  logic [2:0]                         next_settle_count;
  logic [led_port_pkg::WORD_BITS-1:0] next_word_data;
  logic                               next_word_valid;
  logic                               next_programmed;

  // display line bundles
  logic [led_port_pkg::LINE_COUNT-1:0] line_on;
  logic [led_port_pkg::LINE_COUNT-1:0] line_out;
  logic [led_port_pkg::LINE_COUNT-1:0] line_oe;

  // link side: shift register and daisy chain output on the serial clock
  link_shifter u_link (
    .sclk        (sclk),
    .rst_n       (rst_n),
    .sdata_in    (sdata_in),
    .load_strobe (load_strobe),
    .lnk         (lnk.link),
    .sdata_out   (sdata_out)
  );

  // strap pin passes two flops before anything reads it
  always_ff @(posedge clk) begin
    if (!rst_n)
      strap_sync <= 2'b00;
    else
      strap_sync <= {strap_sync[0], variant_cs};
  end

  // variant follows the synchroniser every cycle once it has filled past reset
  always_comb begin
    next_strap_count = strap_count;
    next_cs_mode     = cs_mode;
    if (strap_count != led_port_pkg::STRAP_CLKS) begin
      next_strap_count = strap_count + 2'h1;
    end else if (strap_count == led_port_pkg::STRAP_CLKS) begin
      next_cs_mode     = strap_sync[1];
      next_strap_count = strap_count;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_count <= 2'h0;
      cs_mode     <= 1'b0;
    end else begin
      strap_count <= next_strap_count;
      cs_mode     <= next_cs_mode;
    end
  end
  assign lnk.cs_mode = cs_mode;

  // load strobe into the system domain; the edge compares flops two and three.
  // reset fills the chain at the strobe's idle high level, so a release of
  // reset never looks like a rising strobe and never captures a stale word
  always_ff @(posedge clk) begin
    if (!rst_n)
      strobe_sync <= 3'h7;
    else
      strobe_sync <= {strobe_sync[1:0], load_strobe};
  end
  assign strobe_rise = strobe_sync[1] && !strobe_sync[2];

  // the shift register is static once the strobe is high, so a plain
  // two flop bank is safe here; only the second stage is ever used
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_meta <= led_port_pkg::WORD_RESET;
      word_sync <= led_port_pkg::WORD_RESET;
    end else begin
      word_meta <= lnk.word;
      word_sync <= word_meta;
    end
  end

  // after a strobe rise, wait one serial period of the fastest legal sclk before taking the
  // word, so any last edge near the strobe has settled through the bank
  always_comb begin
    next_state        = state;
    next_settle_count = settle_count;
    next_word_data    = word_data;
    next_word_valid   = 1'b0;
    next_programmed   = programmed;
    case (state)
      led_port_pkg::CAP_IDLE: begin
        if (strobe_rise) begin
          next_state        = led_port_pkg::CAP_SETTLE;
          next_settle_count = 3'h0;
        end
      end
      led_port_pkg::CAP_SETTLE: begin
        // settle length follows the fastest legal serial clock
        if (settle_count == led_port_pkg::SETTLE_CLKS - 3'h1) begin
          next_state      = led_port_pkg::CAP_IDLE;
          next_word_data  = word_sync;
          next_word_valid = 1'b1;
          next_programmed = 1'b1;
        end else begin
          next_settle_count = settle_count + 3'h1;
        end
      end
      default: begin
        next_state = led_port_pkg::CAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state        <= led_port_pkg::CAP_IDLE;
      settle_count <= 3'h0;
      word_data    <= led_port_pkg::WORD_RESET;
      word_valid   <= 1'b0;
      programmed   <= 1'b0;
    end else begin
      state        <= next_state;
      settle_count <= next_settle_count;
      word_data    <= next_word_data;
      word_valid   <= next_word_valid;
      programmed   <= next_programmed;
    end
  end

  // display lines: digits low, then seven segments, then the point
  assign line_on = {point_on, segment_on, digit_on};

  pad_driver u_pads (
    .clk      (clk),
    .rst_n    (rst_n),
    .cs_mode  (cs_mode),
    .blank    (!programmed),
    .line_on  (line_on),
    .line_out (line_out),
    .line_oe  (line_oe)
  );

  // split the bundle back into named line groups
  assign digit_lines_out        = line_out[led_port_pkg::DIGIT_COUNT-1:0];
  assign digit_lines_oe         = line_oe[led_port_pkg::DIGIT_COUNT-1:0];
  assign segment_lines_out      = line_out[led_port_pkg::LINE_COUNT-2:led_port_pkg::DIGIT_COUNT];
  assign segment_lines_oe       = line_oe[led_port_pkg::LINE_COUNT-2:led_port_pkg::DIGIT_COUNT];
  assign decimal_point_line_out = line_out[led_port_pkg::LINE_COUNT-1];
  assign decimal_point_line_oe  = line_oe[led_port_pkg::LINE_COUNT-1];

  // checks on the system clock side

  property p_capture_time;
    @(posedge clk) disable iff (!rst_n)
    (strobe_rise && state == led_port_pkg::CAP_IDLE) |-> ##CAPTURE_LATENCY word_valid;
  endproperty
  a_capture_time: assert property (p_capture_time) else $error("word not taken after strobe");

  property p_capture_value;
    @(posedge clk) disable iff (!rst_n)
    word_valid |-> (word_data == $past(word_sync) && programmed);
  endproperty
  a_capture_value: assert property (p_capture_value) else $error("word taken with wrong value");

  property p_valid_pulse;
    @(posedge clk) disable iff (!rst_n)
    word_valid |=> !word_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("word valid held too long");

  property p_no_spurious;
    @(posedge clk) disable iff (!rst_n)
    (state == led_port_pkg::CAP_IDLE && !strobe_rise) |=> !word_valid[*2];
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("word valid without strobe");

  property p_blank;
    @(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && !programmed && !$past(programmed)) |->
      (!cs_mode || $past(!cs_mode) || line_oe == 16'h0000) &&
      (cs_mode || $past(cs_mode) || (line_oe == 16'hffff && line_out == 16'h00ff));
  endproperty
  a_blank: assert property (p_blank) else $error("display lit before first word");

  property p_digit_off;
    @(posedge clk) disable iff (!rst_n)
    ##1 ($past(programmed) && $stable(cs_mode) && !$past(digit_on[0])) |->
      (cs_mode ? !digit_lines_oe[0] : (digit_lines_oe[0] && digit_lines_out[0]));
  endproperty
  a_digit_off: assert property (p_digit_off) else $error("off digit at wrong level");

  property p_segment_off;
    @(posedge clk) disable iff (!rst_n)
    ##1 ($past(programmed) && $stable(cs_mode) && !$past(segment_on[0])) |->
      (cs_mode ? !segment_lines_oe[0] : (segment_lines_oe[0] && !segment_lines_out[0]));
  endproperty
  a_segment_off: assert property (p_segment_off) else $error("off segment at wrong level");

  property p_point_on;
    @(posedge clk) disable iff (!rst_n)
    ##1 ($past(programmed) && $past(point_on)) |->
      (decimal_point_line_oe && decimal_point_line_out);
  endproperty
  a_point_on: assert property (p_point_on) else $error("lit point not driven high");

  property p_digit_on;
    @(posedge clk) disable iff (!rst_n)
    ##1 ($past(programmed) && $past(digit_on[7])) |->
      (digit_lines_oe[7] && !digit_lines_out[7]);
  endproperty
  a_digit_on: assert property (p_digit_on) else $error("lit digit not sinking");

  property p_programmed_sticky;
    @(posedge clk) disable iff (!rst_n)
    programmed |=> programmed;
  endproperty
  a_programmed_sticky: assert property (p_programmed_sticky) else $error("programmed flag dropped");

  // main scenarios worth seeing
  c_first_word: cover property (@(posedge clk) disable iff (!rst_n)
    !programmed ##1 programmed);
  c_two_words: cover property (@(posedge clk) disable iff (!rst_n)
    word_valid ##[2:400] word_valid);
  c_cs_lit: cover property (@(posedge clk) disable iff (!rst_n)
    cs_mode && programmed && digit_lines_oe != 8'h00);
  c_open_lit: cover property (@(posedge clk) disable iff (!rst_n)
    !cs_mode && programmed && segment_lines_out != 7'h00);
endmodule
`default_nettype wire

// >>> led_port_pkg.sv
/*
  constants, timing counts and types shared by the serial load port of the
  eight digit led driver.
  assumes a 40 MHz system clock and a host serial clock of at most 10 MHz.
*/
`default_nettype none
package led_port_pkg;
  // shift register and display geometry
  localparam int WORD_BITS     = 16;
  localparam int DIGIT_COUNT   = 8;
  localparam int SEGMENT_COUNT = 7;
  localparam int LINE_COUNT    = DIGIT_COUNT + SEGMENT_COUNT + 1;

  // timing, figures in their own units and derived cycle counts
  localparam int CLK_PERIOD_NS      = 25;
  localparam int SCLK_MAX_MHZ       = 10;
  localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
  localparam int SETTLE_CYCLES      = (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SETTLE_CLKS = 3'(SETTLE_CYCLES);
  localparam logic [1:0] STRAP_CLKS  = 2'h2;
  // serial in to serial out delay, in half serial clock cycles (16.5 cycles)
  localparam int DOUT_DELAY_HALF_CYCLES = 33;

  // reset values
  localparam logic [WORD_BITS-1:0]  WORD_RESET = 16'h0000;
  localparam logic [LINE_COUNT-1:0] LINE_RESET = 16'h0000;

  typedef enum logic {CAP_IDLE, CAP_SETTLE} capture_state_e;
endpackage
`default_nettype wire

// >>> shift_if.sv
/*
  carries the link side shift register and the variant select between the
  serial clock domain and the system clock domain.
  assumes the sys end synchronises word before use.
*/
`timescale 1ns/100ps
`default_nettype none
interface shift_if;
  logic [led_port_pkg::WORD_BITS-1:0] word;
  logic                               cs_mode;
  modport link (output word, input cs_mode);
  modport sys  (input word, output cs_mode);
endinterface
`default_nettype wire

// >>> link_shifter.sv
/*
  serial clock domain: 16 bit shift register, one spill stage and the
  falling edge serial output.
  assumes sclk may stop between frames; data flops hold no reset.
*/
`timescale 1ns/100ps
`default_nettype none
module link_shifter (
  input  wire logic sclk,
  input  wire logic rst_n,
  input  wire logic sdata_in,
  input  wire logic load_strobe,
  shift_if.link     lnk,
  output var  logic sdata_out
);
  logic [led_port_pkg::WORD_BITS-1:0] shreg = led_port_pkg::WORD_RESET;
  logic [led_port_pkg::WORD_BITS-1:0] next_shreg;
  logic spill = 1'b0;
  logic next_spill;
  logic dout = 1'b0;
  logic [1:0] rst_sync;
  logic [1:0] cs_sync;
  logic link_rst_n;
  logic cs_l;
  logic shifting;

  // reset and variant reach this domain through two flops each
  always_ff @(posedge sclk) begin
    rst_sync <= {rst_sync[0], rst_n};
    cs_sync  <= {cs_sync[0], lnk.cs_mode};
  end
  assign link_rst_n = rst_sync[1];
  assign cs_l       = cs_sync[1];

  // strobe gates the shift enable directly, in the cs variant only: its setup to sclk is the host's job
  assign shifting = !(cs_l && load_strobe);

  always_comb begin
    next_shreg = shreg;
    next_spill = spill;
    if (shifting) begin
      next_shreg = {shreg[led_port_pkg::WORD_BITS-2:0], sdata_in};
      next_spill = shreg[led_port_pkg::WORD_BITS-1];
    end
  end

  always_ff @(posedge sclk) begin
    shreg <= next_shreg;
    spill <= next_spill;
  end

  // output changes on the falling edge, a half cycle after the spill
  always_ff @(negedge sclk) begin
    dout <= spill;
  end
  assign lnk.word  = shreg;
  assign sdata_out = dout;

  property p_shift_in;
    @(posedge sclk) disable iff (!link_rst_n)
    shifting |=> shreg == {$past(shreg[14:0]), $past(sdata_in)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift register missed a bit");

  property p_cs_hold;
    @(posedge sclk) disable iff (!link_rst_n)
    (cs_l && load_strobe) |=> $stable(shreg);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("shifted while strobe high");

  property p_chain_delay;
    @(posedge sclk) disable iff (!link_rst_n)
    (!cs_l && $past(!cs_l, 17)) |-> dout == $past(sdata_in, 17);
  endproperty
  a_chain_delay: assert property (p_chain_delay) else $error("serial out delay wrong");
endmodule
`default_nettype wire

// >>> pad_driver.sv
/*
  registered drive levels and enables for the digit, segment and point lines.
  assumes common cathode displays: digits sink low, segments source high.
*/
`timescale 1ns/100ps
`default_nettype none
module pad_driver (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              cs_mode,
  input  wire logic                              blank,
  input  wire logic [led_port_pkg::LINE_COUNT-1:0] line_on,
  output var  logic [led_port_pkg::LINE_COUNT-1:0] line_out,
  output var  logic [led_port_pkg::LINE_COUNT-1:0] line_oe
);
  logic [led_port_pkg::LINE_COUNT-1:0] next_out;
  logic [led_port_pkg::LINE_COUNT-1:0] next_oe;

  // {oe, out} for one line; an off line is driven inactive or left floating
  function automatic logic [1:0] drive(input logic on, input logic cs, input logic active);
    if (on)
      drive = {1'b1, active};
    else if (cs)
      drive = 2'b00;
    else
      drive = {1'b1, ~active};
  endfunction

  // lines below the digit count are digits, active low; the rest active high
  for (genvar i = 0; i < led_port_pkg::LINE_COUNT; i++) begin : g_line
    always_comb begin
      {next_oe[i], next_out[i]} = drive(line_on[i] && !blank, cs_mode,
                                        (i >= led_port_pkg::DIGIT_COUNT));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_out <= led_port_pkg::LINE_RESET;
      line_oe  <= led_port_pkg::LINE_RESET;
    end else begin
      line_out <= next_out;
      line_oe  <= next_oe;
    end
  end
endmodule
`default_nettype wire

// >>> led_driver_serial_load_port_end.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> host_model.sv
/*
  behavioural host for the serial load port: drives sclk, data and the
  load strobe, and records what comes back on the serial output.
  assumes the bench calls its tasks one at a time; sclk rests low between frames.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model (
  output var  logic sclk,
  output var  logic sdata_in,
  output var  logic load_strobe,
  input  wire logic sdata_out
);
  // half of the serial period: 100 ns keeps the link at its 10 MHz ceiling
  localparam int HALF_NS = 50;

  logic [31:0] dout_cap;

  // idle: clock still, strobe high, data not left at its last bit
  initial begin
    sclk        = 1'b0;
    sdata_in    = 1'b0;
    load_strobe = 1'b1;
    dout_cap    = 32'h0000_0000;
  end

  // one frame, msb first, one strobe rise at the end; data moves only while sclk is low
  task automatic send_frame(input logic [31:0] bits, input int n);
    load_strobe = 1'b0;
    #HALF_NS;
    for (int i = n - 1; i >= 0; i--) begin
      sdata_in = bits[i];
      #HALF_NS;
      dout_cap = {dout_cap[30:0], sdata_out}; // out settled since the falling edge
      sclk = 1'b1;
      #HALF_NS;
      sclk = 1'b0;
    end
    sdata_in = ~sdata_in;
    #HALF_NS;
    // the last falling edge also presents a bit; take it before the strobe
    dout_cap = {dout_cap[30:0], sdata_out};
    load_strobe = 1'b1; // one rise for the whole chain
  endtask

  // clock pulses with the strobe left high; only the bench asks for these
  task automatic pulse(input int n, input logic b);
    for (int i = 0; i < n; i++) begin
      sdata_in = b;
      #HALF_NS;
      sclk = 1'b1;
      #HALF_NS;
      sclk = 1'b0;
    end
    sdata_in = ~b;
  endtask
endmodule
`default_nettype wire

// >>> led_driver_serial_load_port_tb_top.sv
/*
  self-checking bench for the serial load port: host model on the link side,
  display inputs and strap driven here on the falling clk edge.
  assumes the design holds its own assertions.
*/
`timescale 1ns/100ps
`default_nettype none
module led_driver_serial_load_port_tb_top;
  typedef struct packed {
    logic [7:0] dig;
    logic [6:0] seg;
    logic       pt;
    logic [7:0] dig_out;
    logic [6:0] seg_out;
    logic       pt_out;
  } row_s;

  logic        clk;
  logic        rst_n;
  logic        sclk;
  logic        sdata_in;
  logic        load_strobe;
  logic        variant_cs;
  logic [7:0]  digit_on;
  logic [6:0]  segment_on;
  logic        point_on;
  logic        sdata_out;
  logic [15:0] word_data;
  logic        word_valid;
  logic        programmed;
  logic        cs_mode;
  logic [7:0]  dig_out;
  logic [7:0]  dig_oe;
  logic [6:0]  seg_out;
  logic [6:0]  seg_oe;
  logic        dp_out;
  logic        dp_oe;
  int          fails;
  int          total_checks;
  logic        out_before;
  row_s        rows [4];

  led_driver_serial_load_port dut_u (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .sdata_in(sdata_in), .load_strobe(load_strobe),
    .variant_cs(variant_cs), .digit_on(digit_on), .segment_on(segment_on), .point_on(point_on),
    .sdata_out(sdata_out), .word_data(word_data), .word_valid(word_valid), .programmed(programmed),
    .cs_mode(cs_mode), .digit_lines_out(dig_out), .digit_lines_oe(dig_oe),
    .segment_lines_out(seg_out), .segment_lines_oe(seg_oe),
    .decimal_point_line_out(dp_out), .decimal_point_line_oe(dp_oe)
  );

  host_model host_u (.sclk(sclk), .sdata_in(sdata_in), .load_strobe(load_strobe), .sdata_out(sdata_out));

  // 40 MHz system clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // reset with one link pulse inside it, so the first flop of the link side reset sync sees reset
  task automatic do_reset(input logic v);
    @(negedge clk);
    rst_n      = 1'b0;
    variant_cs = v;
    fork
      host_u.pulse(1, 1'b0);
      repeat (6) @(negedge clk);
    join
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask

  // bounded wait for the capture pulse, then a one cycle drop
  task automatic wait_word(input logic [15:0] exp);
    int n;
    n = 0;
    while (word_valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("word_valid", 32'h1, word_valid);
    check("word_data", exp, word_data);
    check("programmed", 32'h1, programmed);
    @(posedge clk);
    #1;
    check("word_valid_drop", 32'h0, word_valid);
    repeat (10) @(negedge clk);
  endtask

  task automatic apply_lines(input logic [7:0] d, input logic [6:0] s, input logic p);
    @(negedge clk);
    digit_on   = d;
    segment_on = s;
    point_on   = p;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // hang guard, about thirty times the expected run
  initial begin
    #300000;
    fails++;
    end_sim();
  end

  initial begin
    fails        = 0;
    total_checks = 0;
    rst_n        = 1'b0;
    variant_cs   = 1'b0;
    digit_on     = 8'h00;
    segment_on   = 7'h00;
    point_on     = 1'b0;
    // open-drive variant: lit digit sinks low, off digit high, all enabled
    rows[0] = '{8'h01, 7'h3f, 1'b0, 8'hfe, 7'h3f, 1'b0};
    rows[1] = '{8'h80, 7'h06, 1'b1, 8'h7f, 7'h06, 1'b1};
    rows[2] = '{8'hff, 7'h7f, 1'b1, 8'h00, 7'h7f, 1'b1};
    rows[3] = '{8'h00, 7'h00, 1'b0, 8'hff, 7'h00, 1'b0};
    do_reset(1'b0);
    apply_lines(8'hff, 7'h7f, 1'b1);
    check("cs_mode", 32'h0, cs_mode);
    check("programmed_init", 32'h0, programmed);
    check("dig_blank", 32'h0000_ffff, {dig_oe, dig_out});
    check("seg_blank", 32'h0000_3f80, {seg_oe, seg_out});
    check("dp_blank", 32'h0000_0002, {dp_oe, dp_out});
    // two chained words in one frame: the first leaves on sdata_out
    host_u.send_frame(32'hc35a_1e87, 32);
    wait_word(16'h1e87);
    check("chain_out", 32'hc35a, host_u.dout_cap[15:0]);
    for (int i = 0; i < 4; i++) begin
      apply_lines(rows[i].dig, rows[i].seg, rows[i].pt);
      check("dig_out", rows[i].dig_out, dig_out);
      check("seg_out", rows[i].seg_out, seg_out);
      check("dp_out", rows[i].pt_out, dp_out);
      check("oe_open", 32'h0000_ffff, {dig_oe, seg_oe, dp_oe});
    end
    // chip-select variant: off lines float, stray clocks are ignored
    do_reset(1'b1);
    apply_lines(8'h0f, 7'h49, 1'b1);
    check("cs_mode", 32'h1, cs_mode);
    check("oe_cs_blank", 32'h0000_0000, {dig_oe, seg_oe, dp_oe});
    host_u.send_frame(32'h0000_5a3c, 16);
    wait_word(16'h5a3c);
    apply_lines(8'h0f, 7'h49, 1'b1);
    check("dig_cs", 32'h0000_0f00, {dig_oe, dig_out});
    check("seg_cs", 32'h0000_24c9, {seg_oe, seg_out});
    check("dp_cs", 32'h0000_0003, {dp_oe, dp_out});
    out_before = sdata_out;
    host_u.pulse(8, 1'b1);
    check("out_frozen", out_before, sdata_out);
    repeat (10) @(negedge clk);
    host_u.send_frame(32'h0000_00c3, 8);
    wait_word(16'h3cc3);
    end_sim();
  end
endmodule
`default_nettype wire
